// File: dcs_pkg.sv
// Constants for the drive command source selector.
// Assumes one 100 MHz system clock and a synchronous active-low reset.
`default_nettype none

package dcs_pkg;

   localparam int unsigned DCS_SEL_W = 6;
   localparam int unsigned DCS_SYNC_STAGES = 2;

   localparam logic [DCS_SEL_W-1:0] DCS_SEL_CONTACTS = 6'h00;
   localparam logic [DCS_SEL_W-1:0] DCS_SEL_STATE_MACHINE = 6'h01;
   localparam logic [DCS_SEL_W-1:0] DCS_SEL_REMOTE = 6'h02;
   localparam logic [DCS_SEL_W-1:0] DCS_SEL_KP_DIR_CT = 6'h03;
   localparam logic [DCS_SEL_W-1:0] DCS_SEL_KPCT_DIR_CT = 6'h04;
   localparam logic [DCS_SEL_W-1:0] DCS_SEL_3W_DIR_CT = 6'h05;
   localparam logic [DCS_SEL_W-1:0] DCS_SEL_KP_DIR_KP = 6'h0d;
   localparam logic [DCS_SEL_W-1:0] DCS_SEL_KPCT_DIR_KP = 6'h0e;
   localparam logic [DCS_SEL_W-1:0] DCS_SEL_CT_CW = 6'h14;
   localparam logic [DCS_SEL_W-1:0] DCS_SEL_KP_CW = 6'h17;
   localparam logic [DCS_SEL_W-1:0] DCS_SEL_KPCT_CW = 6'h18;
   localparam logic [DCS_SEL_W-1:0] DCS_SEL_CT_CCW = 6'h1e;
   localparam logic [DCS_SEL_W-1:0] DCS_SEL_KP_CCW = 6'h21;
   localparam logic [DCS_SEL_W-1:0] DCS_SEL_KPCT_CCW = 6'h22;
   localparam logic [DCS_SEL_W-1:0] DCS_SEL_CT_DIR_ANY = 6'h2b;
   localparam logic [DCS_SEL_W-1:0] DCS_SEL_ANY_DIR_ANY = 6'h2c;
   localparam logic [DCS_SEL_W-1:0] DCS_SEL_3WKP_DIR_ANY = 6'h2e;

   localparam logic [DCS_SEL_W-1:0] DCS_SEL_RESET = DCS_SEL_CONTACTS;

endpackage : dcs_pkg

`default_nettype wire

// File: dcs_sync.sv
// Two-stage synchroniser for a group of level inputs from pins.
// Assumes the inputs are asynchronous to clock and change slowly.
`default_nettype none

module dcs_sync #(
   parameter int unsigned WIDTH = 1
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1_reg;

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         stage1_reg <= '0;
         sync_out <= '0;
      end
      else
      begin
         stage1_reg <= async_in;
         sync_out <= stage1_reg;
      end
   end

endmodule // dcs_sync

`default_nettype wire

// File: dcs_selector.sv
// Drive command source selector: picks start, stop and direction commands.
// Assumes contact and safety inputs come from pins; keypad and comm inputs share clock.
//
// What this block does
// [R1] Output stage enabled only while both safety enable inputs are high.
// [R2] Setting 0: start, stop and direction from contact inputs only.
// [R3] Setting 1: start, stop and direction from the comm state machine.
// [R4] Setting 2: start, stop and direction from remote logic signals over comm.
// [R5] Setting 3: start/stop from keypad unit, direction from contacts.
// [R6] Setting 4: start/stop from keypad or contacts, direction from contacts.
// [R7] Setting 5: three-wire control, direction and hold signal from contacts.
// [R8] Setting 13: start, stop and direction from keypad unit only.
// [R9] Setting 14: start/stop from keypad or contacts, direction from keypad.
// [R10] Setting 20: start/stop from contacts, direction fixed clockwise.
// [R11] Setting 23: start/stop from keypad unit, direction fixed clockwise.
// [R12] Setting 24: start/stop from keypad or contacts, direction fixed clockwise.
// [R13] Settings 30, 33, 34 mirror 20, 23, 24 with anticlockwise direction.
// [R14] Setting 43: start/stop from contacts, direction from keypad or contacts.
// [R15] Setting 44: start, stop and direction from keypad or contacts.
// [R16] Setting 46: three-wire, direction and hold from contacts or keypad.
// [R17] Changing setting while running keeps running unless new source says stop.
// [R18] Unknown setting codes are refused; the old setting stays active.
`default_nettype none

module dcs_selector
   import dcs_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic safety_enable_a,
   input wire logic safety_enable_b,
   input wire logic contact_start_cw,
   input wire logic contact_start_ccw,
   input wire logic contact_three_wire,
   input wire logic keypad_unit_start,
   input wire logic keypad_unit_stop,
   input wire logic keypad_unit_dir_ccw,
   input wire logic keypad_unit_three_wire,
   input wire logic comm_run,
   input wire logic comm_dir_ccw,
   input wire logic remote_start_cw,
   input wire logic remote_start_ccw,
   input wire logic [dcs_pkg::DCS_SEL_W-1:0] sel_value,
   input wire logic sel_write,
   output logic [dcs_pkg::DCS_SEL_W-1:0] active_sel_reg,
   output logic sel_reject_reg,
   output logic stage_enable_reg,
   output logic drive_run_reg,
   output logic dir_ccw_reg
);

   import dcs_pkg::*;

   logic [4:0] pins_sync;
   logic safety_a_s;
   logic safety_b_s;
   logic ct_cw;
   logic ct_ccw;
   logic ct_hold;
   logic ct_cw_prev_reg;
   logic ct_ccw_prev_reg;
   logic ct_start_edge;
   logic ct_run;
   logic ct_dir_req;
   logic ct_dir_ccw;
   logic rm_run;
   logic rm_dir_ccw;
   logic kp_run_reg;
   logic kp_run_next;
   logic tw_run_reg;
   logic tw_run_next;
   logic tw_keypad_on;
   logic sel_valid;
   logic sel_change;
   logic safety_ok;
   logic demand_run;
   logic demand_ccw;
   logic any_dir_ccw;

   dcs_sync #(
      .WIDTH(5)
   ) u_pin_sync (
      .clock(clock),
      .rst_n(rst_n),
      .async_in({safety_enable_a, safety_enable_b, contact_start_cw,
                 contact_start_ccw, contact_three_wire}),
      .sync_out(pins_sync)
   );

   assign safety_a_s = pins_sync[4];
   assign safety_b_s = pins_sync[3];
   assign ct_cw = pins_sync[2];
   assign ct_ccw = pins_sync[1];
   assign ct_hold = pins_sync[0];

   // Both enables must be high for the output stage and for any run command.
   assign safety_ok = safety_a_s & safety_b_s; // see [R1]

   // Contact commands: either start line runs; clockwise wins when both are on.
   assign ct_run = ct_cw | ct_ccw;
   assign ct_dir_req = ct_cw | ct_ccw;
   assign ct_dir_ccw = ct_ccw & ~ct_cw;
   assign ct_start_edge = (ct_cw & ~ct_cw_prev_reg) | (ct_ccw & ~ct_ccw_prev_reg);
   assign rm_run = remote_start_cw | remote_start_ccw;
   assign rm_dir_ccw = remote_start_ccw & ~remote_start_cw;

   // Contacts give direction when they request one, otherwise the keypad does.
   assign any_dir_ccw = ct_dir_req ? ct_dir_ccw : keypad_unit_dir_ccw;

   // A three-wire setting with keypad participation.
   assign tw_keypad_on = (active_sel_reg == DCS_SEL_3WKP_DIR_ANY);

   // Only the listed codes are accepted.
   always_comb
   begin
      sel_valid = 1'b0;
      if (sel_value == DCS_SEL_CONTACTS || sel_value == DCS_SEL_STATE_MACHINE ||
          sel_value == DCS_SEL_REMOTE || sel_value == DCS_SEL_KP_DIR_CT ||
          sel_value == DCS_SEL_KPCT_DIR_CT || sel_value == DCS_SEL_3W_DIR_CT)
      begin
         sel_valid = 1'b1;
      end
      else if (sel_value == DCS_SEL_KP_DIR_KP || sel_value == DCS_SEL_KPCT_DIR_KP ||
               sel_value == DCS_SEL_CT_CW || sel_value == DCS_SEL_KP_CW ||
               sel_value == DCS_SEL_KPCT_CW)
      begin
         sel_valid = 1'b1;
      end
      else if (sel_value == DCS_SEL_CT_CCW || sel_value == DCS_SEL_KP_CCW ||
               sel_value == DCS_SEL_KPCT_CCW || sel_value == DCS_SEL_CT_DIR_ANY ||
               sel_value == DCS_SEL_ANY_DIR_ANY || sel_value == DCS_SEL_3WKP_DIR_ANY)
      begin
         sel_valid = 1'b1;
      end
   end

   assign sel_change = sel_write & sel_valid & (sel_value != active_sel_reg);

   // Source selection register and refusal flag.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         active_sel_reg <= DCS_SEL_RESET;
         sel_reject_reg <= 1'b0;
      end
      else
      begin
         sel_reject_reg <= sel_write & ~sel_valid; // see [R18]
         if (sel_write && sel_valid)
         begin
            active_sel_reg <= sel_value; // see [R18]
         end
      end
   end

   // Previous contact levels for start-edge detection.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         ct_cw_prev_reg <= 1'b0;
         ct_ccw_prev_reg <= 1'b0;
      end
      else
      begin
         ct_cw_prev_reg <= ct_cw;
         ct_ccw_prev_reg <= ct_ccw;
      end
   end

   // Keypad run latch: start sets, stop clears and wins over start.
   always_comb
   begin
      kp_run_next = kp_run_reg;
      if (sel_change)
      begin
         kp_run_next = drive_run_reg; // see [R17]
      end
      if (keypad_unit_start)
      begin
         kp_run_next = 1'b1;
      end
      if (keypad_unit_stop || !safety_ok)
      begin
         kp_run_next = 1'b0;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         kp_run_reg <= 1'b0;
      end
      else
      begin
         kp_run_reg <= kp_run_next;
      end
   end

   // Three-wire latch: a start edge sets it, dropping the hold line clears it.
   always_comb
   begin
      tw_run_next = tw_run_reg;
      if (sel_change)
      begin
         tw_run_next = drive_run_reg; // see [R17]
      end
      if (ct_start_edge || (tw_keypad_on && keypad_unit_start))
      begin
         tw_run_next = 1'b1; // see [R7] [R16]
      end
      if (tw_keypad_on)
      begin
         if (!(ct_hold || keypad_unit_three_wire) || keypad_unit_stop)
         begin
            tw_run_next = 1'b0; // see [R16]
         end
      end
      else if (!ct_hold)
      begin
         tw_run_next = 1'b0; // see [R7]
      end
      if (!safety_ok)
      begin
         tw_run_next = 1'b0;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         tw_run_reg <= 1'b0;
      end
      else
      begin
         tw_run_reg <= tw_run_next;
      end
   end

   // Command routing per active setting; direction holds when no source gives one.
   always_comb
   begin
      demand_run = 1'b0;
      demand_ccw = dir_ccw_reg;
      case (active_sel_reg)
         DCS_SEL_CONTACTS:
         begin
            demand_run = ct_run; // see [R2]
            demand_ccw = ct_dir_req ? ct_dir_ccw : dir_ccw_reg;
         end
         DCS_SEL_STATE_MACHINE:
         begin
            demand_run = comm_run; // see [R3]
            demand_ccw = comm_dir_ccw;
         end
         DCS_SEL_REMOTE:
         begin
            demand_run = rm_run; // see [R4]
            demand_ccw = rm_run ? rm_dir_ccw : dir_ccw_reg;
         end
         DCS_SEL_KP_DIR_CT:
         begin
            demand_run = kp_run_next; // see [R5]
            demand_ccw = ct_dir_req ? ct_dir_ccw : dir_ccw_reg;
         end
         DCS_SEL_KPCT_DIR_CT:
         begin
            demand_run = kp_run_next | ct_run; // see [R6]
            demand_ccw = ct_dir_req ? ct_dir_ccw : dir_ccw_reg;
         end
         DCS_SEL_3W_DIR_CT:
         begin
            demand_run = tw_run_next; // see [R7]
            demand_ccw = ct_dir_req ? ct_dir_ccw : dir_ccw_reg;
         end
         DCS_SEL_KP_DIR_KP:
         begin
            demand_run = kp_run_next; // see [R8]
            demand_ccw = keypad_unit_dir_ccw;
         end
         DCS_SEL_KPCT_DIR_KP:
         begin
            demand_run = kp_run_next | ct_run; // see [R9]
            demand_ccw = keypad_unit_dir_ccw;
         end
         DCS_SEL_CT_CW:
         begin
            demand_run = ct_run; // see [R10]
            demand_ccw = 1'b0;
         end
         DCS_SEL_KP_CW:
         begin
            demand_run = kp_run_next; // see [R11]
            demand_ccw = 1'b0;
         end
         DCS_SEL_KPCT_CW:
         begin
            demand_run = kp_run_next | ct_run; // see [R12]
            demand_ccw = 1'b0;
         end
         DCS_SEL_CT_CCW:
         begin
            demand_run = ct_run; // see [R13]
            demand_ccw = 1'b1;
         end
         DCS_SEL_KP_CCW:
         begin
            demand_run = kp_run_next; // see [R13]
            demand_ccw = 1'b1;
         end
         DCS_SEL_KPCT_CCW:
         begin
            demand_run = kp_run_next | ct_run; // see [R13]
            demand_ccw = 1'b1;
         end
         DCS_SEL_CT_DIR_ANY:
         begin
            demand_run = ct_run; // see [R14]
            demand_ccw = any_dir_ccw;
         end
         DCS_SEL_ANY_DIR_ANY:
         begin
            demand_run = kp_run_next | ct_run; // see [R15]
            demand_ccw = any_dir_ccw;
         end
         DCS_SEL_3WKP_DIR_ANY:
         begin
            demand_run = tw_run_next; // see [R16]
            demand_ccw = any_dir_ccw;
         end
         default:
         begin
            demand_run = 1'b0;
            demand_ccw = dir_ccw_reg;
         end
      endcase
   end

   // Registered outputs; run is blocked unless both safety enables are high.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         stage_enable_reg <= 1'b0;
         drive_run_reg <= 1'b0;
         dir_ccw_reg <= 1'b0;
      end
      else
      begin
         stage_enable_reg <= safety_ok; // see [R1]
         drive_run_reg <= demand_run & safety_ok; // see [R1] [R17]
         dir_ccw_reg <= demand_ccw;
      end
   end

endmodule // dcs_selector

`default_nettype wire

// File: dcs_far_side.sv
// Far side model: safety pins, contacts, keypad unit and comm interface.
// Assumes its tasks are called just after a rising clock edge.
`default_nettype none
module dcs_far_side (
   input wire logic clock,
   output logic safety_enable_a,
   output logic safety_enable_b,
   output logic contact_start_cw,
   output logic contact_start_ccw,
   output logic contact_three_wire,
   output logic keypad_unit_start,
   output logic keypad_unit_stop,
   output logic keypad_unit_dir_ccw,
   output logic keypad_unit_three_wire,
   output logic comm_run,
   output logic comm_dir_ccw,
   output logic remote_start_cw,
   output logic remote_start_ccw
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {keypad_unit_start, keypad_unit_stop} = 2'b00;
   task automatic safe(input logic [1:0] v);
      {safety_enable_a, safety_enable_b} = v;
   endtask
   task automatic pins(input logic [2:0] v);
      {contact_start_cw, contact_start_ccw, contact_three_wire} = v;
   endtask
   task automatic keys(input logic [1:0] v);
      {keypad_unit_dir_ccw, keypad_unit_three_wire} = v;
   endtask
   task automatic comm(input logic [3:0] v);
      {comm_run, comm_dir_ccw, remote_start_cw, remote_start_ccw} = v;
   endtask
   task automatic kp(input logic [1:0] v);
      {keypad_unit_start, keypad_unit_stop} = v;
      @(posedge clock);
      #1;
      {keypad_unit_start, keypad_unit_stop} = 2'b00;
      @(posedge clock);
      #1;
   endtask
endmodule // dcs_far_side
`default_nettype wire

// File: dcs_selector_properties.sv
// Port checks for the command source selector.
// Assumes reset lasts three edges or more.
`default_nettype none
module dcs_selector_properties
   import dcs_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic safety_enable_a,
   input wire logic safety_enable_b,
   input wire logic keypad_unit_start,
   input wire logic keypad_unit_stop,
   input wire logic [dcs_pkg::DCS_SEL_W-1:0] sel_value,
   input wire logic sel_write,
   input wire logic [dcs_pkg::DCS_SEL_W-1:0] active_sel_reg,
   input wire logic sel_reject_reg,
   input wire logic stage_enable_reg,
   input wire logic drive_run_reg,
   input wire logic dir_ccw_reg
);
   logic [2:0] safe_cnt_reg;
   logic code_ok;
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   always_comb code_ok = sel_value inside {[6'h00:6'h05], 6'h0d, 6'h0e, 6'h14, 6'h17, 6'h18,
      6'h1e, 6'h21, 6'h22, 6'h2b, 6'h2c, 6'h2e};
   always_ff @(posedge clock)
   begin
      if (!rst_n || !(safety_enable_a && safety_enable_b))
         safe_cnt_reg <= 3'h0;
      else if (safe_cnt_reg != 3'h7)
         safe_cnt_reg <= safe_cnt_reg + 3'h1;
   end
   a_stage_safety: assert property (
      stage_enable_reg |-> $past(safety_enable_a, 3) && $past(safety_enable_b, 3))
      else $error("Stage on without safety.");
   a_stage_on: assert property (
      safe_cnt_reg == 3'h7 |-> stage_enable_reg)
      else $error("Stage off.");
   a_keypad_start: assert property (
      active_sel_reg == 6'h0d && $stable(active_sel_reg) && safe_cnt_reg == 3'h7 && !sel_write
      && keypad_unit_start && !keypad_unit_stop |=> drive_run_reg)
      else $error("Start ignored.");
   a_keypad_stop: assert property (
      active_sel_reg inside {6'h03, 6'h0d, 6'h17, 6'h21} && $stable(active_sel_reg)
      && !sel_write && keypad_unit_stop |=> !drive_run_reg)
      else $error("Stop ignored.");
   a_reject_bad: assert property (
      sel_write && !code_ok |=> sel_reject_reg && $stable(active_sel_reg))
      else $error("Bad code taken.");
   a_accept_good: assert property (
      sel_write && code_ok |=> active_sel_reg == $past(sel_value) && !sel_reject_reg)
      else $error("Good code refused.");
   a_dir_cw: assert property (
      active_sel_reg inside {6'h14, 6'h17, 6'h18} && $stable(active_sel_reg) && drive_run_reg
      |-> !dir_ccw_reg)
      else $error("Not clockwise.");
   a_dir_ccw: assert property (
      active_sel_reg inside {6'h1e, 6'h21, 6'h22} && $stable(active_sel_reg) && drive_run_reg
      |-> dir_ccw_reg)
      else $error("Not anticlockwise.");
endmodule // dcs_selector_properties
bind dcs_selector dcs_selector_properties i_dcs_selector_properties (.clock, .rst_n,
   .safety_enable_a, .safety_enable_b, .keypad_unit_start, .keypad_unit_stop, .sel_value,
   .sel_write, .active_sel_reg, .sel_reject_reg, .stage_enable_reg, .drive_run_reg,
   .dir_ccw_reg);
`default_nettype wire

// File: dcs_selector_test.sv
// Self-checking bench for the command source selector.
// Assumes the far side model drives every command input.
`default_nettype none
module dcs_selector_test;
   timeunit 1ns;
   timeprecision 1ps;
   import dcs_pkg::*;
   logic clock, rst_n, sel_write, sel_reject_reg, stage_enable_reg, drive_run_reg, dir_ccw_reg;
   logic safety_enable_a, safety_enable_b, contact_start_cw, contact_start_ccw;
   logic contact_three_wire, keypad_unit_start, keypad_unit_stop, keypad_unit_dir_ccw;
   logic keypad_unit_three_wire, comm_run, comm_dir_ccw, remote_start_cw, remote_start_ccw;
   logic [DCS_SEL_W-1:0] sel_value, active_sel_reg;
   logic [5:0] fc [6] = '{6'h14, 6'h17, 6'h18, 6'h1e, 6'h21, 6'h22};
   logic [5:0] fk = 6'b010010;
   int n_fail, compares;
   int cyc = 0;
   dcs_selector i_dcs_selector (.clock, .rst_n, .safety_enable_a, .safety_enable_b,
      .contact_start_cw, .contact_start_ccw, .contact_three_wire, .keypad_unit_start,
      .keypad_unit_stop, .keypad_unit_dir_ccw, .keypad_unit_three_wire, .comm_run, .comm_dir_ccw,
      .remote_start_cw, .remote_start_ccw, .sel_value, .sel_write, .active_sel_reg,
      .sel_reject_reg, .stage_enable_reg, .drive_run_reg, .dir_ccw_reg);
   dcs_far_side i_dcs_far_side (.clock, .safety_enable_a, .safety_enable_b, .contact_start_cw,
      .contact_start_ccw, .contact_three_wire, .keypad_unit_start, .keypad_unit_stop,
      .keypad_unit_dir_ccw, .keypad_unit_three_wire, .comm_run, .comm_dir_ccw,
      .remote_start_cw, .remote_start_ccw);
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic chk1(input logic got, input logic exp);
      compares++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk6(input logic [5:0] got, input logic [5:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic out(input logic r, input logic d);
      chk1(drive_run_reg, r);
      chk1(dir_ccw_reg, d);
   endtask
   task automatic wsel(input logic [5:0] v, input logic rej);
      sel_value = v;
      sel_write = 1'b1;
      step(1);
      chk1(sel_reject_reg, rej);
      sel_write = 1'b0;
      step(2);
   endtask
   task automatic pins(input logic [2:0] v, input int n);
      i_dcs_far_side.pins(v);
      step(n);
   endtask
   task automatic end_test(input string name);
      $display("test %s done", name);
   endtask
   task automatic complete_run;
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         n_fail++;
         complete_run;
      end
   end
   initial
   begin
      n_fail = 0;
      compares = 0;
      rst_n = 1'b0;
      sel_write = 1'b0;
      sel_value = 6'h00;
      i_dcs_far_side.safe(2'b11);
      i_dcs_far_side.pins(3'b000);
      i_dcs_far_side.keys(2'b00);
      i_dcs_far_side.comm(4'b0000);
      step(20);
      chk1(drive_run_reg, 1'b0);
      rst_n = 1'b1;
      step(4);
      chk6(active_sel_reg, 6'h00);
      chk1(stage_enable_reg, 1'b1);
      pins(3'b100, 4);
      out(1'b1, 1'b0);
      pins(3'b010, 4);
      out(1'b1, 1'b1);
      i_dcs_far_side.comm(4'b1111);
      pins(3'b000, 4);
      chk1(drive_run_reg, 1'b0);
      wsel(6'h01, 1'b0);
      out(1'b1, 1'b1);
      i_dcs_far_side.comm(4'b0001);
      step(2);
      chk1(drive_run_reg, 1'b0);
      wsel(6'h02, 1'b0);
      out(1'b1, 1'b1);
      i_dcs_far_side.comm(4'b0010);
      step(2);
      out(1'b1, 1'b0);
      i_dcs_far_side.comm(4'b0000);
      step(2);
      chk1(drive_run_reg, 1'b0);
      end_test("remote");
      wsel(6'h0d, 1'b0);
      i_dcs_far_side.keys(2'b10);
      i_dcs_far_side.kp(2'b10);
      out(1'b1, 1'b1);
      pins(3'b100, 4);
      chk1(dir_ccw_reg, 1'b1);
      i_dcs_far_side.kp(2'b01);
      chk1(drive_run_reg, 1'b0);
      i_dcs_far_side.keys(2'b00);
      wsel(6'h03, 1'b0);
      pins(3'b010, 4);
      chk1(drive_run_reg, 1'b0);
      i_dcs_far_side.kp(2'b10);
      out(1'b1, 1'b1);
      i_dcs_far_side.kp(2'b01);
      chk1(drive_run_reg, 1'b0);
      pins(3'b000, 4);
      for (int i = 0; i < 6; i++)
      begin
         wsel(fc[i], 1'b0);
         i_dcs_far_side.keys({i < 3, 1'b0});
         if (fk[i])
            i_dcs_far_side.kp(2'b10);
         else
            i_dcs_far_side.pins(i < 3 ? 3'b010 : 3'b100);
         step(4);
         out(1'b1, i >= 3);
         i_dcs_far_side.pins(3'b000);
         i_dcs_far_side.kp(2'b01);
         step(2);
         chk1(drive_run_reg, 1'b0);
      end
      end_test("forced");
      wsel(6'h2c, 1'b0);
      i_dcs_far_side.keys(2'b10);
      i_dcs_far_side.kp(2'b10);
      out(1'b1, 1'b1);
      pins(3'b100, 4);
      out(1'b1, 1'b0);
      i_dcs_far_side.pins(3'b000);
      i_dcs_far_side.kp(2'b01);
      step(2);
      chk1(drive_run_reg, 1'b0);
      wsel(6'h0e, 1'b0);
      pins(3'b100, 4);
      out(1'b1, 1'b1);
      pins(3'b000, 4);
      wsel(6'h04, 1'b0);
      i_dcs_far_side.kp(2'b10);
      chk1(drive_run_reg, 1'b1);
      pins(3'b100, 4);
      chk1(dir_ccw_reg, 1'b0);
      i_dcs_far_side.pins(3'b000);
      i_dcs_far_side.kp(2'b01);
      step(2);
      wsel(6'h2b, 1'b0);
      i_dcs_far_side.kp(2'b10);
      chk1(drive_run_reg, 1'b0);
      pins(3'b010, 4);
      out(1'b1, 1'b1);
      pins(3'b000, 4);
      end_test("either");
      wsel(6'h05, 1'b0);
      pins(3'b001, 4);
      pins(3'b101, 4);
      out(1'b1, 1'b0);
      pins(3'b001, 4);
      chk1(drive_run_reg, 1'b1);
      pins(3'b000, 4);
      chk1(drive_run_reg, 1'b0);
      wsel(6'h2e, 1'b0);
      i_dcs_far_side.keys(2'b01);
      pins(3'b100, 4);
      chk1(drive_run_reg, 1'b1);
      pins(3'b000, 4);
      chk1(drive_run_reg, 1'b1);
      i_dcs_far_side.keys(2'b00);
      step(2);
      chk1(drive_run_reg, 1'b0);
      end_test("three_wire");
      wsel(6'h00, 1'b0);
      pins(3'b100, 4);
      wsel(6'h14, 1'b0);
      chk1(drive_run_reg, 1'b1);
      wsel(6'h17, 1'b0);
      chk1(drive_run_reg, 1'b1);
      i_dcs_far_side.kp(2'b01);
      chk1(drive_run_reg, 1'b0);
      wsel(6'h3f, 1'b1);
      wsel(6'h06, 1'b1);
      chk6(active_sel_reg, 6'h17);
      wsel(6'h00, 1'b0);
      step(4);
      i_dcs_far_side.safe(2'b01);
      step(4);
      chk1(stage_enable_reg, 1'b0);
      chk1(drive_run_reg, 1'b0);
      end_test("change_and_safety");
      i_dcs_far_side.safe(2'b11);
      rst_n = 1'b0;
      step(3);
      chk1(stage_enable_reg, 1'b0);
      rst_n = 1'b1;
      step(4);
      chk1(stage_enable_reg, 1'b1);
      chk6(active_sel_reg, 6'h00);
      end_test("second_reset");
      complete_run;
   end
endmodule // dcs_selector_test
`default_nettype wire
